// ---- imc_memory_ctrl.sv ----
`timescale 1ns/1ps
`include "imc_map.svh"

// What this block does
// - 32 KB bit-aliased SRAM, 128 KB flash.
// - SRAM is two word-interleaved 32-bit banks.
// - Read after same-bank write stalls one cycle.
// - Write then other-bank read runs back to back.
// - SRAM decoded from 0x2000_0000.
// - Bit alias: base plus offset*32 plus bit*4.
// - Alias access touches only the addressed bit.
// - Boot ROM decoded at 0x0100_0000.
// - Flash erases per 1-KB unit to ones.
// - Word program only clears bits.
// - Protection chosen per 2-KB granule.
// - Read-only granule refuses program and erase.
// - Execute-only granule allows fetches only.
// - Flash times its own pulses from cycles-per-us.
// - Reload value resets for maximum clock.
// - Flash accesses wait while flash is busy.
// - Protected program/erase refused, optional interrupt.
module imc_memory_ctrl #(
  parameter logic [15:0] PROG_US  = `IMC_PROG_US,
  parameter logic [15:0] ERASE_US = `IMC_ERASE_US
) (
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  input  wire imc_pkg::imc_req_t         bus_req,
  output imc_pkg::imc_rsp_t              bus_rsp,
  output logic                           bus_busy,
  input  wire imc_pkg::imc_fcmd_t        flash_cmd,
  input  wire logic [`IMC_GRANULES-1:0]  prog_enable,
  input  wire logic [`IMC_GRANULES-1:0]  read_enable,
  input  wire logic                      access_irq_mask,
  input  wire logic                      usec_reload_wr,
  input  wire logic [7:0]                microsecond_reload_value,
  output logic                           flash_busy,
  output logic                           flash_done,
  output logic                           flash_refused,
  output logic                           access_irq
);
  import imc_pkg::*;

  imc_req_t     held_ff;
  logic         busy_ff;
  imc_rsp_t     rsp_ff;
  logic         last_wr_ff;
  logic         last_bank_ff;

  imc_req_t     cur;
  logic         cur_vld;
  imc_region_t  region;
  logic [31:0]  sram_off;
  logic [31:0]  alias_off;
  logic [31:0]  flash_off;
  logic [31:0]  rom_off;
  logic [14:0]  eff_off;
  logic         is_ram;
  logic         bank;
  logic [11:0]  widx;
  logic [4:0]   bitn;
  logic [31:0]  ram_word;
  logic [31:0]  flash_word;
  logic [31:0]  rd_data;
  logic         conflict;
  logic         flash_wait;
  logic         bad;
  logic         go;
  logic [31:0]  bank_rd [`IMC_BANKS];

  logic [7:0]   microsecond_reload_value_ff;
  logic [7:0]   tick_cnt_ff;
  logic         tick;
  imc_fstate_t  fstate_ff;
  logic [15:0]  us_left_ff;
  logic [16:0]  fl_addr_ff;
  logic [31:0]  fl_data_ff;
  logic         fl_busy_ff;
  logic         fl_done_ff;
  logic         fl_refused_ff;
  logic         acc_irq_ff;
  logic         cmd_idle;
  logic         cmd_allowed;
  logic         fl_start;
  logic         fl_refuse;
  logic         fl_finish;

  logic [31:0]  flash_mem [`IMC_FLASH_WORDS];

  // A stalled request is replayed from the held copy, so the requester
  // need not hold its request while the busy flag is up.
  always_comb begin
    cur     = busy_ff ? held_ff : bus_req;
    cur_vld = busy_ff | bus_req.valid;
  end

  always_comb begin
    sram_off  = cur.addr - `IMC_SRAM_BASE;
    alias_off = cur.addr - `IMC_ALIAS_BASE;
    flash_off = cur.addr - `IMC_FLASH_BASE;
    rom_off   = cur.addr - `IMC_ROM_BASE;
    if (sram_off < `IMC_SRAM_SIZE) begin
      region = RG_SRAM;
    end else if (alias_off < `IMC_ALIAS_SIZE) begin
      region = RG_ALIAS;
    end else if (flash_off < `IMC_FLASH_SIZE) begin
      region = RG_FLASH;
    end else if (rom_off < `IMC_ROM_SIZE) begin
      region = RG_ROM;
    end else begin
      region = RG_NONE;
    end
  end

  // The alias offset divided by 32 is the byte offset; bits 4:2 pick
  // the bit inside that byte.
  always_comb begin
    is_ram = (region == RG_SRAM) || (region == RG_ALIAS);
    if (region == RG_ALIAS) begin
      eff_off = alias_off[`IMC_AOFF_MSB:`IMC_AOFF_LSB];
    end else begin
      eff_off = sram_off[`IMC_SOFF_MSB:`IMC_SOFF_LSB];
    end
    bank = eff_off[`IMC_BANK_BIT];
    widx = eff_off[`IMC_WIDX_MSB:`IMC_WIDX_LSB];
    bitn = {eff_off[`IMC_LANE_MSB:`IMC_LANE_LSB],
            alias_off[`IMC_ABIT_MSB:`IMC_ABIT_LSB]};
  end

  // Only a read can collide; a read from the other bank, or any
  // write, goes ahead in the very next cycle.
  always_comb begin
    conflict = is_ram && !cur.write && last_wr_ff
               && (bank == last_bank_ff);
    flash_wait = (region == RG_FLASH) && fl_busy_ff;
    go = cur_vld && !conflict && !flash_wait;
  end

  always_comb begin
    ram_word   = bank_rd[bank];
    flash_word = flash_mem[flash_off[`IMC_FW_MSB:`IMC_FW_LSB]];
    bad        = 1'b0;
    rd_data    = 32'h0000_0000;
    case (region)
      RG_SRAM: begin
        rd_data = ram_word;
      end
      RG_ALIAS: begin
        rd_data = {31'h0000_0000, ram_word[bitn]};
      end
      RG_FLASH: begin
        // Flash only changes through the command port.
        bad = cur.write
              || (!cur.fetch && !read_enable[
                  flash_off[`IMC_GRAN_MSB:`IMC_GRAN_LSB]]);
        rd_data = flash_word;
      end
      RG_ROM: begin
        bad     = cur.write;
        rd_data = `IMC_ROM_BLANK;
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  genvar gb;
  generate
    for (gb = 0; gb < `IMC_BANKS; gb++) begin : g_bank
      logic [31:0] mem [`IMC_BANK_WORDS];
      logic        hit;
      assign hit = go && is_ram && cur.write && (bank == 1'(gb));
      assign bank_rd[gb] = mem[widx];
      // The alias write updates one bit in one cycle, so no other
      // master can slip in between a read and a write-back.
      always_ff @(posedge mclk) begin
        if (hit && region == RG_ALIAS) begin
          mem[widx][bitn] <= cur.wdata[0];
        end else if (hit) begin
          mem[widx] <= cur.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_ff <= 1'b0;
      held_ff <= '0;
    end else begin
      busy_ff <= cur_vld && (conflict || flash_wait);
      held_ff <= cur;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      last_wr_ff   <= 1'b0;
      last_bank_ff <= 1'b0;
    end else begin
      last_wr_ff   <= go && is_ram && cur.write;
      last_bank_ff <= bank;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= go;
      rsp_ff.fault <= go && bad;
      if (go && !bad && !cur.write) begin
        rsp_ff.rdata <= rd_data;
      end else begin
        rsp_ff.rdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      microsecond_reload_value_ff <= `IMC_USEC_RST;
    end else if (usec_reload_wr) begin
      microsecond_reload_value_ff <= microsecond_reload_value;
    end
  end

  // Restarting the countdown at each start makes the first tick land
  // a full microsecond later, so pulses are never short.
  assign tick = (tick_cnt_ff == `IMC_TICK_ZERO);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_ff <= `IMC_USEC_RST;
    end else if (fl_start || tick) begin
      tick_cnt_ff <= microsecond_reload_value_ff;
    end else begin
      tick_cnt_ff <= tick_cnt_ff - 8'h01;
    end
  end

  always_comb begin
    cmd_idle    = (fstate_ff == FL_IDLE);
    cmd_allowed = prog_enable[
      flash_cmd.addr[`IMC_GRAN_MSB:`IMC_GRAN_LSB]];
    fl_start  = cmd_idle && flash_cmd.start && cmd_allowed;
    fl_refuse = cmd_idle && flash_cmd.start && !cmd_allowed;
    fl_finish = !cmd_idle && tick && (us_left_ff == `IMC_US_LAST);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fstate_ff  <= FL_IDLE;
      us_left_ff <= 16'h0000;
      fl_addr_ff <= '0;
      fl_data_ff <= 32'h0000_0000;
    end else begin
      case (fstate_ff)
        FL_IDLE: begin
          if (fl_start) begin
            fl_addr_ff <= flash_cmd.addr;
            fl_data_ff <= flash_cmd.data;
            if (flash_cmd.erase) begin
              fstate_ff  <= FL_ERASE;
              us_left_ff <= ERASE_US;
            end else begin
              fstate_ff  <= FL_PROG;
              us_left_ff <= PROG_US;
            end
          end
        end
        FL_PROG, FL_ERASE: begin
          if (fl_finish) begin
            fstate_ff <= FL_IDLE;
          end else if (tick) begin
            us_left_ff <= us_left_ff - 16'h0001;
          end
        end
        default: begin
          fstate_ff <= FL_IDLE;
        end
      endcase
    end
  end

  // The array has no reset: its contents are nonvolatile, so a fresh
  // simulation starts unknown until a unit is erased.
  always_ff @(posedge mclk) begin
    if (fl_finish && fstate_ff == FL_ERASE) begin
      for (int i = 0; i < `IMC_UNIT_WORDS; i++) begin
        flash_mem[{fl_addr_ff[`IMC_UNIT_MSB:`IMC_UNIT_LSB], 8'(i)}]
          <= 32'hFFFF_FFFF;
      end
    end else if (fl_finish) begin
      flash_mem[fl_addr_ff[`IMC_FW_MSB:`IMC_FW_LSB]] <=
        flash_mem[fl_addr_ff[`IMC_FW_MSB:`IMC_FW_LSB]]
        & fl_data_ff;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fl_busy_ff    <= 1'b0;
      fl_done_ff    <= 1'b0;
      fl_refused_ff <= 1'b0;
      acc_irq_ff    <= 1'b0;
    end else begin
      fl_busy_ff    <= fl_start || (fl_busy_ff && !fl_finish);
      fl_done_ff    <= fl_finish;
      fl_refused_ff <= fl_refuse;
      acc_irq_ff    <= fl_refuse && access_irq_mask;
    end
  end

  assign bus_rsp       = rsp_ff;
  assign bus_busy      = busy_ff;
  assign flash_busy    = fl_busy_ff;
  assign flash_done    = fl_done_ff;
  assign flash_refused = fl_refused_ff;
  assign access_irq    = acc_irq_ff;

endmodule : imc_memory_ctrl

// ---- imc_map.svh ----
`ifndef IMC_MAP_SVH
`define IMC_MAP_SVH

`define IMC_FLASH_BASE  32'h0000_0000
`define IMC_FLASH_SIZE  32'h0002_0000
`define IMC_ROM_BASE    32'h0100_0000
`define IMC_ROM_SIZE    32'h0000_1000
`define IMC_ROM_BLANK   32'h0000_0000
`define IMC_SRAM_BASE   32'h2000_0000
`define IMC_SRAM_SIZE   32'h0000_8000
`define IMC_ALIAS_BASE  32'h2200_0000
`define IMC_ALIAS_SIZE  32'h0010_0000

`define IMC_SOFF_MSB    14
`define IMC_SOFF_LSB    0
`define IMC_AOFF_MSB    19
`define IMC_AOFF_LSB    5
`define IMC_ABIT_MSB    4
`define IMC_ABIT_LSB    2
`define IMC_LANE_MSB    1
`define IMC_LANE_LSB    0
`define IMC_BANK_BIT    2
`define IMC_WIDX_MSB    14
`define IMC_WIDX_LSB    3
`define IMC_FW_MSB      16
`define IMC_FW_LSB      2
`define IMC_GRAN_MSB    16
`define IMC_GRAN_LSB    11
`define IMC_UNIT_MSB    16
`define IMC_UNIT_LSB    10

`define IMC_BANKS       2
`define IMC_BANK_WORDS  4096
`define IMC_FLASH_WORDS 32768
`define IMC_UNIT_WORDS  256
`define IMC_GRANULES    64

`define IMC_USEC_RST    8'h63
`define IMC_PROG_US     16'h0014
`define IMC_ERASE_US    16'h2710
`define IMC_US_LAST     16'h0001
`define IMC_TICK_ZERO   8'h00

`endif

// ---- imc_pkg.sv ----
package imc_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    logic [31:0] addr;
    logic [31:0] wdata;
  } imc_req_t;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [31:0] rdata;
  } imc_rsp_t;

  typedef struct packed {
    logic        start;
    logic        erase;
    logic [16:0] addr;
    logic [31:0] data;
  } imc_fcmd_t;

  typedef enum logic [2:0] {
    RG_NONE, RG_FLASH, RG_ROM, RG_SRAM, RG_ALIAS
  } imc_region_t;

  typedef enum logic [1:0] {
    FL_IDLE, FL_PROG, FL_ERASE
  } imc_fstate_t;

endpackage : imc_pkg

// ---- imc_asserts.sv ----
`timescale 1ns/1ps
module imc_asserts
  import imc_pkg::*;
#(
  parameter logic [15:0] PROG_US  = 16'h0014,
  parameter logic [15:0] ERASE_US = 16'h2710
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire imc_req_t    bus_req,
  input wire imc_rsp_t    bus_rsp,
  input wire logic        bus_busy,
  input wire imc_fcmd_t   flash_cmd,
  input wire logic [63:0] prog_enable,
  input wire logic [63:0] read_enable,
  input wire logic        access_irq_mask,
  input wire logic        usec_reload_wr,
  input wire logic [7:0]  microsecond_reload_value,
  input wire logic        flash_busy,
  input wire logic        flash_done,
  input wire logic        flash_refused,
  input wire logic        access_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic        wr_ff;
  logic        bk_ff;
  logic        er_ff;
  logic [7:0]  rl_ff;
  logic [31:0] cnt_ff;
  wire sram  = bus_req.addr[31:15] == 17'h0_4000;
  wire in_al = bus_req.addr[31:20] == 12'h220;
  // An alias address reaches its bank through bit 2 of its byte offset.
  wire bank  = in_al ? bus_req.addr[7] : bus_req.addr[2];
  wire take  = bus_req.valid && !bus_busy && (sram || in_al);
  wire rd    = take && !bus_req.write;
  wire same  = wr_ff && bank == bk_ff;
  wire ok_st = flash_cmd.start && !flash_busy;
  wire prot  = !prog_enable[flash_cmd.addr[16:11]];
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ff <= 1'b0;
      bk_ff <= 1'b0;
    end else begin
      wr_ff <= take && bus_req.write;
      bk_ff <= bank;
    end
  end
  // The reload copy lets the op length be checked against the live setting.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rl_ff  <= 8'h63;
      er_ff  <= 1'b0;
      cnt_ff <= '0;
    end else begin
      if (usec_reload_wr) rl_ff <= microsecond_reload_value;
      if (ok_st) er_ff <= flash_cmd.erase;
      cnt_ff <= ok_st ? '0 : cnt_ff + {31'h0, flash_busy};
    end
  end
  a_stall_one:
    assert property (rd && same |=> bus_busy ##1 (!bus_busy && bus_rsp.valid))
    else $error("same bank read not stalled one cycle");
  a_other_bank:
    assert property (rd && !same |=> !bus_busy && bus_rsp.valid)
    else $error("read was delayed");
  a_irq_mask:
    assert property (access_irq == (flash_refused && $past(access_irq_mask)))
    else $error("access irq does not follow mask");
  a_done_ends_busy:
    assert property (flash_done |-> !flash_busy && $past(flash_busy))
    else $error("done without busy ending");
  a_start_busy:
    assert property (ok_st && !prot |=> flash_busy && !flash_refused)
    else $error("accepted start did not set busy");
  a_protect_refuse:
    assert property (ok_st && prot |=> flash_refused && !flash_busy)
    else $error("protected start not refused");
  a_refused_pulse:
    assert property (flash_refused |=> !flash_refused)
    else $error("refused longer than one cycle");
  a_op_length:
    assert property (flash_done |-> cnt_ff == ({24'h0, rl_ff} + 32'h0000_0001)
      * {16'h0, er_ff ? ERASE_US : PROG_US})
    else $error("flash op length wrong");
endmodule : imc_asserts

bind imc_memory_ctrl imc_asserts #(.PROG_US(PROG_US), .ERASE_US(ERASE_US))
  chk (.*);

// ---- imc_core_model.sv ----
`timescale 1ns/1ps
module imc_core_model
  import imc_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     sys_rst,
  input  wire logic     bus_busy,
  input  wire imc_req_t next_req,
  output imc_req_t      bus_req
);
  // A released bus shows inverted lines so stale values never look valid.
  always_ff @(negedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_req <= '0;
    end else if (!bus_busy) begin
      bus_req <= next_req.valid ? next_req
                 : imc_req_t'({1'b0, ~bus_req[65:0]});
    end
  end
endmodule : imc_core_model

// ---- internal_memory_controller_test.sv ----
`timescale 1ns/1ps
module internal_memory_controller_test;
  import imc_pkg::*;
  typedef struct packed {
    imc_req_t    req;
    logic        fault;
    logic [31:0] rdata;
  } imc_row_t;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  imc_req_t    req_in = '0;
  imc_req_t    bus_req;
  imc_rsp_t    bus_rsp;
  imc_rsp_t    s;
  imc_fcmd_t   flash_cmd = '0;
  logic        bus_busy, flash_busy, flash_done, flash_refused, access_irq;
  logic [63:0] prog_enable = '1;
  logic [63:0] read_enable = '1;
  logic        access_irq_mask = 1'b1;
  logic        usec_reload_wr = 1'b0;
  logic [7:0]  microsecond_reload_value = 8'h04;
  int          errors = 0;
  int          check_count = 0;
  int          n;
  imc_row_t    rows[12];
  imc_memory_ctrl #(.PROG_US(16'h0002), .ERASE_US(16'h0003)) uut (.*);
  imc_core_model core (.mclk, .sys_rst, .bus_busy, .next_req(req_in),
    .bus_req);
  initial forever #5 mclk = ~mclk;
  function automatic imc_req_t rq(logic w, logic f, logic [31:0] a,
                                  logic [31:0] d);
    return '{1'b1, w, f, a, d};
  endfunction : rq
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic access(imc_req_t r);
    @(posedge mclk);
    #1 req_in = r;
    @(posedge mclk);
    #1 req_in = '0;
    n = 0;
    while (bus_rsp.valid !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      #1 n++;
    end
    s = bus_rsp;
  endtask : access
  task automatic b2b(logic [31:0] ra, logic [31:0] stall, logic [31:0] ed);
    @(posedge mclk);
    #1 req_in = rq(1, 0, 32'h2000_0010, 32'h1357_9BDF);
    // The read goes up one cycle after the write, so the two reach the controller
    // at consecutive edges and the wait count starts with the read.
    access(rq(0, 0, ra, '0));
    check("stall", n, stall);
    check("b2b data", s.rdata, ed);
  endtask : b2b
  task automatic fstart(logic er, logic [16:0] a, logic [31:0] d);
    @(negedge mclk) flash_cmd <= '{1'b1, er, a, d};
    @(negedge mclk) flash_cmd <= '0;
  endtask : fstart
  task automatic fop(logic er, logic [16:0] a, logic [31:0] d);
    fstart(er, a, d);
    n = 0;
    while (flash_done !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask : fop
  task automatic wrap_up();
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #60000;
    errors++;
    wrap_up();
  end
  initial begin
    rows = '{
      '{rq(1, 0, 32'h2000_0000, 32'hA5A5_0001), 1'b0, 32'h0},
      '{rq(1, 0, 32'h2000_7FFC, 32'h1234_5678), 1'b0, 32'h0},
      '{rq(0, 0, 32'h2000_0000, 32'h0), 1'b0, 32'hA5A5_0001},
      '{rq(0, 0, 32'h2000_7FFC, 32'h0), 1'b0, 32'h1234_5678},
      '{rq(1, 0, 32'h2000_8000, 32'h0), 1'b1, 32'h0},
      '{rq(0, 0, 32'h0100_0000, 32'h0), 1'b0, 32'h0},
      '{rq(1, 0, 32'h0000_0010, 32'h0), 1'b1, 32'h0},
      '{rq(1, 0, 32'h2200_000C, 32'h1), 1'b0, 32'h0},
      '{rq(0, 0, 32'h2200_000C, 32'h0), 1'b0, 32'h1},
      '{rq(1, 0, 32'h2200_0060, 32'h0), 1'b0, 32'h0},
      '{rq(0, 0, 32'h2000_0000, 32'h0), 1'b0, 32'hA4A5_0009},
      '{rq(0, 0, 32'h4000_0000, 32'h0), 1'b1, 32'h0}};
    repeat (20) @(posedge mclk);
    check("reset outs", {bus_rsp.valid, bus_busy, flash_busy, flash_done,
      flash_refused, access_irq}, '0);
    @(negedge mclk) sys_rst <= 1'b0;
    foreach (rows[i]) begin
      access(rows[i].req);
      check("fault", {31'h0, s.fault}, {31'h0, rows[i].fault});
      check("rdata", s.rdata, rows[i].rdata);
    end
    b2b(32'h2000_0010, '0 + 1, 32'h1357_9BDF);
    b2b(32'h2000_7FFC, '0, 32'h1234_5678);
    fop(1'b1, 17'h0_0400, '0);
    check("erase time", n, 32'h0000_012C);
    // Pretend the core was reclocked to 5 MHz before programming flash.
    @(negedge mclk) usec_reload_wr <= 1'b1;
    @(negedge mclk) usec_reload_wr <= 1'b0;
    fop(1'b0, 17'h0_0400, 32'h0F0F_F0F0);
    check("prog time", n, 32'h0000_000A);
    fstart(1'b0, 17'h0_0400, 32'hFF00_FF00);
    access(rq(0, 0, 32'h0000_0400, '0));
    check("held", {31'h0, flash_busy}, '0);
    check("and prog", s.rdata, 32'h0F00_F000);
    @(negedge mclk) prog_enable[0] <= 1'b0;
    access(rq(0, 0, 32'h0000_07FC, '0));
    check("erased", s.rdata, 32'hFFFF_FFFF);
    for (int m = 0; m < 2; m++) begin
      @(negedge mclk) access_irq_mask <= m[0];
      fstart(!m[0], 17'h0_07FC, '0);
      check("refused", {flash_busy, flash_refused}, 32'h1);
      check("irq", {31'h0, access_irq}, m);
    end
    @(negedge mclk) read_enable[0] <= 1'b0;
    access(rq(0, 0, 32'h0000_0400, '0));
    check("data blocked", {31'h0, s.fault}, 32'h1);
    access(rq(0, 1, 32'h0000_0400, '0));
    check("fetch", s.rdata, 32'h0F00_F000);
    // A reset in the middle of a program must abort it and bring the
    // reload value back to its maximum-clock setting.
    fstart(1'b0, 17'h0_0800, 32'h0000_FFFF);
    @(negedge mclk) sys_rst <= 1'b1;
    @(negedge mclk);
    check("mid reset", {bus_busy, flash_busy, flash_done}, '0);
    sys_rst <= 1'b0;
    fop(1'b0, 17'h0_0800, 32'h0000_FFFF);
    check("reset prog", n, 32'h0000_00C8);
    wrap_up();
  end
endmodule : internal_memory_controller_test
